// *** src/dai_indicator.sv ***
// Drive activity indicator: four active-low lamp outputs from per-port activity.
// Assumes activity and ROM signals come from core_clk logic; the mode pin is a board strap.
// Operation
// - Four lamp outputs, each driven low to light its lamp.
// - Paired mode: output zero lights when channel 0 or 1 is active.
// - Paired mode: output one lights when channel 2 or 3 is active.
// - Direct mode pin low: each port drives only its own output.
// - During ROM transfers the shared pins serve only the ROM.
// - All four enabled: ROM data-out pin is channel 3 lamp.
// - All four enabled: ROM clock pin is channel 2 lamp.
`timescale 1ns/1ps
`default_nettype none
`include "dai_defines.svh"
module dai_indicator
	import dai_pkg::*;
#(
	parameter int NUM_CHAN = `DAI_NUM_CHAN
) (
	input wire logic core_clk, // Core clock, 250 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire dai_activity_t activity, // Per-port outstanding transfer flags.
	input wire dai_rom_t rom, // Serial ROM clock, data-out and busy.
	input wire logic direct_port_mode_n, // Mode strap pin, low selects direct-port mode.
	output logic activity_out_0, // Lamp 0, active low.
	output logic activity_out_1, // Lamp 1, active low.
	output logic activity_out_2, // Shared ROM clock pin / lamp 2.
	output logic activity_out_3, // Shared ROM data-out pin / lamp 3.
	output logic rom_serial_data_out // Same level as activity_out_3 for the ROM side.
);
	initial
	begin
		if (NUM_CHAN != 4)
			$error("dai_indicator: NUM_CHAN must be four.");
	end

	logic [0:0] mode_sync;
	logic direct_mode;
	logic [3:0] lamp_on;
	logic [3:0] lamp_d;
	logic [3:0] lamp_level;
	logic [3:0] pair_busy;
	logic [3:0] rom_owns;
	logic [3:0] rom_level;
	genvar g;
	logic [3:0] lamp_q;
	logic rom_dout_q;

	// The strap is an outside pin and crosses two flops first.
	dai_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_mode_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(direct_port_mode_n),
		.sync_out(mode_sync)
	);
	assign direct_mode = ~mode_sync[0];

	// Outputs 0 and 1 each merge a channel pair in paired mode; 2 and 3 stay dark there outside ROM transfers.
	assign pair_busy[0] = activity.busy[0] | activity.busy[1];
	assign pair_busy[1] = activity.busy[2] | activity.busy[3];
	assign pair_busy[2] = 1'b0;
	assign pair_busy[3] = 1'b0;

	// A ROM transfer takes the two shared pins away from the lamps.
	assign rom_owns = {rom.rom_active, rom.rom_active, 2'b00};
	assign rom_level = {rom.rom_dout, rom.rom_clk, 2'b11};

	generate
		for (g = 0; g < NUM_CHAN; g = g + 1)
		begin : g_lamp
			assign lamp_on[g] = direct_mode ? activity.busy[g] : pair_busy[g];
			assign lamp_level[g] = lamp_on[g] ? `DAI_LAMP_ON : `DAI_LAMP_OFF;
			assign lamp_d[g] = rom_owns[g] ? rom_level[g] : lamp_level[g];
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lamp_q <= `DAI_LAMP_RESET;
			rom_dout_q <= `DAI_LAMP_OFF;
		end
		else
		begin
			lamp_q <= lamp_d;
			rom_dout_q <= lamp_d[`DAI_ROM_DOUT_OUT];
		end
	end

	assign activity_out_0 = lamp_q[0];
	assign activity_out_1 = lamp_q[1];
	assign activity_out_2 = lamp_q[2];
	assign activity_out_3 = lamp_q[3];
	assign rom_serial_data_out = rom_dout_q;

	// Checks.
	a_pair0_lamp: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && (activity.busy[0] || activity.busy[1])) |=> !activity_out_0)
		else $error("Paired lamp 0 not lit.");
	a_pair1_lamp: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && !activity.busy[2] && !activity.busy[3]) |=> activity_out_1)
		else $error("Paired lamp 1 lit without activity.");
	a_direct_lamp1: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mode_sync[0] |=> (activity_out_1 == !$past(activity.busy[1])))
		else $error("Direct lamp 1 wrong.");
	a_rom_clk_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		rom.rom_active |=> (activity_out_2 == $past(rom.rom_clk)))
		else $error("ROM clock not passed.");
	a_ch3_lamp: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!mode_sync[0] && !rom.rom_active && activity.busy[3]) |=> !activity_out_3)
		else $error("Channel 3 lamp not lit.");
	a_ch2_lamp: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!mode_sync[0] && !rom.rom_active && !activity.busy[2]) |=> activity_out_2)
		else $error("Channel 2 lamp lit while idle.");
	a_lamp_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(activity.busy == 4'h0 && !rom.rom_active) |=> (lamp_q == 4'hf))
		else $error("Lamp lit with no activity.");
	a_dout_mirror: assert property (@(posedge core_clk) disable iff (!rst_n)
		rom.rom_active |=> (rom_serial_data_out == $past(rom.rom_dout)))
		else $error("Data-out pin does not carry the ROM data.");

	property p_pair0_idle;
		@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && !activity.busy[0] && !activity.busy[1]) |=> activity_out_0;
	endproperty
	a_pair0_idle: assert property (p_pair0_idle)
		else $error("Paired lamp 0 lit without activity.");

	property p_pair1_lit;
		@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && (activity.busy[2] || activity.busy[3])) |=> !activity_out_1;
	endproperty
	a_pair1_lit: assert property (p_pair1_lit)
		else $error("Paired lamp 1 not lit.");

	property p_pair_both;
		@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && activity.busy == 4'hf) |=> (!activity_out_0 && !activity_out_1);
	endproperty
	a_pair_both: assert property (p_pair_both)
		else $error("Paired lamps not both lit.");

	property p_shared_dark;
		@(posedge core_clk) disable iff (!rst_n)
		(mode_sync[0] && !rom.rom_active) |=> (activity_out_2 && activity_out_3);
	endproperty
	a_shared_dark: assert property (p_shared_dark)
		else $error("Shared lamp lit in paired mode.");

	property p_direct_lamp0;
		@(posedge core_clk) disable iff (!rst_n)
		!mode_sync[0] |=> (activity_out_0 == !$past(activity.busy[0]));
	endproperty
	a_direct_lamp0: assert property (p_direct_lamp0)
		else $error("Direct lamp 0 wrong.");

	property p_direct_all;
		@(posedge core_clk) disable iff (!rst_n)
		(!mode_sync[0] && activity.busy == 4'hf && !rom.rom_active) |=> (lamp_q == 4'h0);
	endproperty
	a_direct_all: assert property (p_direct_all)
		else $error("Direct lamps not all lit.");

	property p_ch2_lit;
		@(posedge core_clk) disable iff (!rst_n)
		(!mode_sync[0] && !rom.rom_active && activity.busy[2]) |=> !activity_out_2;
	endproperty
	a_ch2_lit: assert property (p_ch2_lit)
		else $error("Channel 2 lamp not lit.");

	property p_ch3_idle;
		@(posedge core_clk) disable iff (!rst_n)
		(!mode_sync[0] && !rom.rom_active && !activity.busy[3]) |=> activity_out_3;
	endproperty
	a_ch3_idle: assert property (p_ch3_idle)
		else $error("Channel 3 lamp lit while idle.");

	property p_rom_dout_pass;
		@(posedge core_clk) disable iff (!rst_n)
		rom.rom_active |=> (activity_out_3 == $past(rom.rom_dout));
	endproperty
	a_rom_dout_pass: assert property (p_rom_dout_pass)
		else $error("ROM data not passed.");

	property p_rom_owns_clk;
		@(posedge core_clk) disable iff (!rst_n)
		(rom.rom_active && rom.rom_clk && activity.busy[2]) |=> activity_out_2;
	endproperty
	a_rom_owns_clk: assert property (p_rom_owns_clk)
		else $error("Lamp 2 drove the ROM clock pin during a transfer.");

	property p_rom_owns_dout;
		@(posedge core_clk) disable iff (!rst_n)
		(rom.rom_active && rom.rom_dout && activity.busy[3]) |=> activity_out_3;
	endproperty
	a_rom_owns_dout: assert property (p_rom_owns_dout)
		else $error("Lamp 3 drove the ROM data pin during a transfer.");

	property p_mode_sync;
		@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n, 2) |-> (mode_sync[0] == $past(direct_port_mode_n, 2));
	endproperty
	a_mode_sync: assert property (p_mode_sync)
		else $error("Mode strap not seen two cycles later.");

	property p_reset_dark;
		@(posedge core_clk)
		(!rst_n ##1 !rst_n) |-> (lamp_q == `DAI_LAMP_RESET);
	endproperty
	a_reset_dark: assert property (p_reset_dark)
		else $error("Lamp lit during reset.");

	c_paired: cover property (@(posedge core_clk) mode_sync[0] && activity.busy[1]);
	c_direct: cover property (@(posedge core_clk) !mode_sync[0] && activity.busy[3]);
	c_rom: cover property (@(posedge core_clk) rom.rom_active ##1 !rom.rom_active);
	c_mode_switch: cover property (@(posedge core_clk) mode_sync[0] ##1 !mode_sync[0]);
	c_all_lit: cover property (@(posedge core_clk) lamp_q == 4'h0);
endmodule
`default_nettype wire

// *** common/dai_defines.svh ***
// Constants for the drive activity indicator block.
// Assumes inclusion by bare name from the common folder.
`ifndef DAI_DEFINES_SVH
`define DAI_DEFINES_SVH
`define DAI_NUM_CHAN 4
`define DAI_PAIR0_OUT 0
`define DAI_PAIR1_OUT 1
`define DAI_ROM_CLK_OUT 2
`define DAI_ROM_DOUT_OUT 3
`define DAI_LAMP_OFF 1'b1
`define DAI_LAMP_ON 1'b0
`define DAI_LAMP_RESET 4'hf
`endif

// *** common/dai_pkg.sv ***
// Types for the drive activity indicator block.
// Assumes nothing beyond the defines header.
package dai_pkg;
	typedef struct packed
	{
		logic [3:0] busy;
	} dai_activity_t;
	typedef struct packed
	{
		logic rom_clk;
		logic rom_dout;
		logic rom_active;
	} dai_rom_t;
endpackage

// *** src/dai_sync.sv ***
// Two-flop synchroniser for a bus of pin levels.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module dai_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic core_clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
	output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	initial
	begin
		if (WIDTH < 1)
			$error("dai_sync: WIDTH must be at least one.");
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** verif/dai_led_model.sv ***
// Board lamps: a lamp is lit while its pin is pulled low.
// Assumes the pins come straight from the indicator outputs.
`timescale 1ns/1ps
`default_nettype none
module dai_led_model (
	input wire logic [3:0] lamp_n, // Lamp pins, active low.
	output logic [3:0] lit // Lamp is on.
);
	assign lit = ~lamp_n;
endmodule
`default_nettype wire

// *** verif/drive_activity_indicator_tb_top.sv ***
// Bench for the activity indicator: random activity and ROM stimulus in paired mode, then in direct mode.
// Assumes the package and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module drive_activity_indicator_tb_top;
	import dai_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	dai_activity_t activity = '0;
	dai_rom_t rom = '0;
	logic direct_port_mode_n = 1'b1;
	wire logic [3:0] lamp_n;
	wire logic rom_pin;
	wire logic [3:0] lit;
	int err_total = 0;
	int checked = 0;
	int seed = 39;
	int r;
	always #2 core_clk = ~core_clk;
	dai_indicator uut (.core_clk(core_clk), .rst_n(rst_n), .activity(activity), .rom(rom),
		.direct_port_mode_n(direct_port_mode_n), .activity_out_0(lamp_n[0]),
		.activity_out_1(lamp_n[1]), .activity_out_2(lamp_n[2]),
		.activity_out_3(lamp_n[3]), .rom_serial_data_out(rom_pin));
	dai_led_model leds (.lamp_n(lamp_n), .lit(lit));
	function automatic logic [3:0] want(input logic m, input logic [3:0] b, input dai_rom_t q);
		logic [3:0] e;
		e = m ? {2'b11, ~(b[3] | b[2]), ~(b[1] | b[0])} : ~b;
		if (q.rom_active)
			e[3:2] = {q.rom_dout, q.rom_clk};
		return e;
	endfunction
	task automatic check(input logic [3:0] e);
		checked++;
		if (lamp_n !== e || rom_pin !== e[3] || lit !== ~e)
		begin
			err_total++;
			$display("unexpected at %0t: lamps %b, wanted %b", $time, lamp_n, e);
		end
	endtask
	task automatic results;
		$display("mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		#1;
		check(4'hf);
		rst_n = 1'b1;
		for (int m = 1; m >= 0; m--)
		begin
			direct_port_mode_n = m[0];
			repeat (4) @(posedge core_clk);
			#1;
			for (int i = 0; i < 200; i++)
			begin
				r = (i == 0) ? 15 : $random(seed);
				activity.busy = r[3:0];
				rom = r[6:4];
				@(posedge core_clk);
				#1;
				check(want(m[0], activity.busy, rom));
			end
		end
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check(4'hf);
		rst_n = 1'b1;
		repeat (2)
		begin
			@(posedge core_clk);
			#1;
			check(want(1'b1, activity.busy, rom));
		end
		repeat (2) @(posedge core_clk);
		#1;
		check(want(1'b0, activity.busy, rom));
		results;
	end
	initial
	begin
		#4000;
		err_total++;
		results;
	end
endmodule
`default_nettype wire
